// ===== test_tx_pcs_encode_serialize_path.sv
// Self-checking testbench for the transmit coding and serializing path
`timescale 1ns/1ps
`default_nettype none
module test_tx_pcs_encode_serialize_path;
    logic ref_clk, arst_n, tx_logic_reset, word_take, serial_out, running_disparity, ovr_en, ovr_val;
    tx_pcs_pkg::tx_cfg_t cfg_s;
    tx_pcs_pkg::tx_cfg_t cfg;
    tx_pcs_pkg::tx_word_t parallel_in;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int takes[$];
    logic bitlog[int];
    logic [23:0] ws[$];
    logic [9:0] xs[$];
    always_comb begin
        cfg = cfg_s;
        cfg.disparity_override_en = ovr_en;
        cfg.disparity_override_value = ovr_val;
    end
    tx_pcs_encode_serialize_path dut (.ref_clk(ref_clk), .arst_n(arst_n), .tx_logic_reset(tx_logic_reset), .cfg(cfg),
        .parallel_in(parallel_in), .word_take(word_take), .serial_out(serial_out),
        .running_disparity(running_disparity));
    tx_word_source src (.ref_clk(ref_clk), .arst_n(arst_n), .word_take(word_take), .parallel_in(parallel_in),
        .ovr_en(ovr_en), .ovr_val(ovr_val));
    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Line log indexed by edge; a group loaded at take edge e sits at e+1..e+10
    always @(posedge ref_clk) begin
        bitlog[cyc] = serial_out;
        if (word_take === 1'h1) takes.push_back(cyc);
        cyc++;
    end
    function automatic logic [23:0] wd(logic en, logic val, logic [15:0] d, logic [1:0] c);
        return {en, val, 4'h0, d, c};
    endfunction
    function automatic logic [9:0] grp(int e);
        logic [9:0] g;
        for (int j = 0; j < 10; j++) g[j] = bitlog[e + 1 + j];
        return g;
    endfunction
    function automatic logic [9:0] xf(logic [9:0] c, logic rv, logic iv);
        logic [9:0] r;
        for (int i = 0; i < 10; i++) r[i] = rv ? c[9 - i] : c[i];
        return iv ? ~r : r;
    endfunction
    task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Four groups before the first take (reset comma and three sync groups when encoding), then the user groups listed in xs
    task automatic phase(input logic [7:0] mode);
        int per;
        int e;
        per = (mode[6] && !mode[7]) ? 2 : 1;
        #1 arst_n = 1'h0;
        tx_logic_reset = 1'h1;
        cfg_s = mode;
        takes.delete();
        repeat (6) @(posedge ref_clk);
        #1 arst_n = 1'h1;
        repeat (45) @(posedge ref_clk);
        #1 tx_logic_reset = 1'h0;
        foreach (ws[i]) src.q.push_back(ws[i]);
        for (int k = 0; k < 300 && takes.size() < (xs.size() - 4) / per; k++) @(posedge ref_clk);
        // The second half of a split word ends twenty cycles after its take
        repeat (22) @(posedge ref_clk);
        if (takes.size() < (xs.size() - 4) / per) begin
            error_cnt++;
            $display("[ERR] takes expected %0d seen %0d", (xs.size() - 4) / per, takes.size());
            conclude();
        end
        foreach (xs[i]) begin
            e = (i < 4) ? takes[0] - 40 + 10 * i : takes[(i - 4) / per] + 10 * ((i - 4) % per);
            chk($sformatf("group %0d", i), xf(xs[i], mode[3] && !mode[7], mode[2]), grp(e));
        end
    endtask
    initial begin
        arst_n = 1'h0;
        tx_logic_reset = 1'h1;
        cfg_s = 8'h00;
        ws = {wd(1'h0, 1'h0, 16'h0000, 2'h0), wd(1'h0, 1'h0, 16'h00BC, 2'h1), wd(1'h0, 1'h0, 16'h00BC, 2'h0),
            wd(1'h1, 1'h1, 16'h00BC, 2'h1), wd(1'h0, 1'h1, 16'h00BC, 2'h1), wd(1'h1, 1'h1, 16'h00BC, 2'h1)};
        xs = {10'h17C, 10'h17C, 10'h283, 10'h17C, 10'h346, 10'h283, 10'h15C, 10'h283, 10'h17C, 10'h283};
        phase(8'h20);
        ws = {wd(1'h0, 1'h0, 16'hBC00, 2'h2), wd(1'h0, 1'h0, 16'hBC00, 2'h2)};
        xs = {10'h17C, 10'h17C, 10'h283, 10'h17C, 10'h346, 10'h283, 10'h0B9, 10'h17C};
        phase(8'h6C);
        xs = {10'h17C, 10'h17C, 10'h283, 10'h17C, 10'h346, 10'h346};
        phase(8'hE8);
        // Raw 10-bit words split in two, mirrored; zero groups until the first take
        ws = {wd(1'h0, 1'h0, 16'hABCD, 2'h0)};
        xs = {10'h000, 10'h000, 10'h000, 10'h000, 10'h3CD, 10'h02A};
        phase(8'h58);
        conclude();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        $display("[ERR] watchdog expected finish seen timeout");
        conclude();
    end
endmodule // test_tx_pcs_encode_serialize_path
`default_nettype wire

// ===== tx_path_assertions.sv
// Concurrent checks on the ports of the transmit coding and serializing path
`timescale 1ns/1ps
`default_nettype none
module tx_path_checker (
    input wire logic ref_clk, // Bit clock
    input wire logic arst_n, // Async reset, active low
    input wire logic tx_logic_reset, // Digital reset
    input wire tx_pcs_pkg::tx_cfg_t cfg, // Mode controls
    input wire tx_pcs_pkg::tx_word_t parallel_in, // Offered word
    input wire logic word_take, // Take pulse
    input wire logic serial_out, // Line bit
    input wire logic running_disparity // Disparity, 1 positive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire logic one_char = cfg.enc_en && !cfg.byte_ser_en && !cfg.gigabit_ethernet_mode;
    wire logic period10 = cfg.enc_en && (!cfg.byte_ser_en || cfg.gigabit_ethernet_mode);
    wire logic period20 = cfg.enc_en && cfg.byte_ser_en && !cfg.gigabit_ethernet_mode;
    wire logic char_bc = parallel_in.data[7:0] == tx_pcs_pkg::COMMA_CHAR;
    wire logic plain_take = word_take && one_char && !tx_logic_reset;
    sequence s_rst_long;
        tx_logic_reset[*8] ##1 tx_logic_reset[*4];
    endsequence
    sequence s_run9;
        !tx_logic_reset[*8] ##1 !tx_logic_reset;
    endsequence
    sequence s_run19;
        !tx_logic_reset[*8] ##1 !tx_logic_reset[*8] ##1 !tx_logic_reset[*3];
    endsequence
    // The clear lands one cycle into reset, so after twelve reset cycles it must have landed
    property p_rst_quiet;
        s_rst_long |-> !word_take && !running_disparity;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("take or positive rd in reset");
    // A comma stream never holds more than five ones in a row, in either bit order
    property p_rst_comma;
        s_rst_long ##1 serial_out[*5] |=> !serial_out || !cfg.enc_en;
    endproperty
    a_rst_comma: assert property (p_rst_comma) else $error("run of ones too long in reset");
    property p_sync_hold;
        $fell(tx_logic_reset) && cfg.enc_en |-> !word_take[*8] ##1 !word_take[*8] ##1 !word_take[*4];
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("take during sync groups");
    property p_gap;
        word_take |=> !word_take[*7];
    endproperty
    a_gap: assert property (p_gap) else $error("takes too close");
    property p_step10;
        word_take && period10 && !tx_logic_reset ##1 s_run9 |=> word_take;
    endproperty
    a_step10: assert property (p_step10) else $error("single word period broken");
    property p_step20;
        word_take && period20 && !tx_logic_reset ##1 s_run19 |=> word_take;
    endproperty
    a_step20: assert property (p_step20) else $error("split word period broken");
    property p_forced;
        plain_take && cfg.disparity_override_en && char_bc && parallel_in.ctrl[0]
            |=> running_disparity != $past(cfg.disparity_override_value);
    endproperty
    a_forced: assert property (p_forced) else $error("forced comma rd wrong");
    property p_comma_flip;
        plain_take && !cfg.disparity_override_en && char_bc && parallel_in.ctrl[0]
            |=> running_disparity != $past(running_disparity);
    endproperty
    a_comma_flip: assert property (p_comma_flip) else $error("comma did not flip rd");
    property p_neutral;
        plain_take && !cfg.disparity_override_en && char_bc && !parallel_in.ctrl[0] |=> $stable(running_disparity);
    endproperty
    a_neutral: assert property (p_neutral) else $error("neutral data group moved rd");
endmodule // tx_path_checker
bind tx_pcs_encode_serialize_path tx_path_checker u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .tx_logic_reset(tx_logic_reset), .cfg(cfg), .parallel_in(parallel_in), .word_take(word_take),
    .serial_out(serial_out), .running_disparity(running_disparity));
`default_nettype wire

// ===== tx_pcs_encode_serialize_path.sv
// Transmit byte serializer, 8b/10b encoder, reversal, inversion and bit serializer
// Overview of operation
// - Byte serializer splits wide word into two
// - Gigabit ethernet mode bypasses the byte serializer
// - Low half sent first, high half second
// - Encode character plus flag by running disparity
// - Reset clears disparity, sends negative comma continuously when the encoder is on
// - After reset three commas before user characters when the encoder is on
// - Pipeline latency may precede the first comma
// - Flag low gives data, high gives control
// - Control characters are not checked for validity
// - Override enable forces the group's disparity, except in gigabit ethernet mode
// - Override value ignored while override disabled
// - Later groups continue from forced group's disparity
// - Invert enable flips every serializer input bit
// - Bit reversal mirrors the serializer word, except in gigabit ethernet mode
// - Words load per parallel period, LSB first
// - Code groups follow standard 8b/10b tables
// - Word fetch at parallel rate, halved when splitting
`timescale 1ns/1ps
`default_nettype none
module tx_pcs_encode_serialize_path (
    input wire logic ref_clk,                         // Serial bit clock
    input wire logic arst_n,                          // Asynchronous reset, active low
    input wire logic tx_logic_reset,                  // Transmit digital reset, synchronous, high
    input wire tx_pcs_pkg::tx_cfg_t cfg,              // Mode and feature controls
    input wire tx_pcs_pkg::tx_word_t parallel_in,     // Word from the phase compensation FIFO
    output logic word_take,                           // Pulse: parallel_in taken this cycle
    output logic serial_out,                          // Serial line data
    output logic running_disparity                    // Current running disparity, 1 positive
);
    function automatic logic [5:0] tbl6(input logic [4:0] x);
        case (x)
            5'h00: tbl6 = 6'h27;
            5'h01: tbl6 = 6'h1D;
            5'h02: tbl6 = 6'h2D;
            5'h03: tbl6 = 6'h31;
            5'h04: tbl6 = 6'h35;
            5'h05: tbl6 = 6'h29;
            5'h06: tbl6 = 6'h19;
            5'h07: tbl6 = 6'h38;
            5'h08: tbl6 = 6'h39;
            5'h09: tbl6 = 6'h25;
            5'h0A: tbl6 = 6'h15;
            5'h0B: tbl6 = 6'h34;
            5'h0C: tbl6 = 6'h0D;
            5'h0D: tbl6 = 6'h2C;
            5'h0E: tbl6 = 6'h1C;
            5'h0F: tbl6 = 6'h17;
            5'h10: tbl6 = 6'h1B;
            5'h11: tbl6 = 6'h23;
            5'h12: tbl6 = 6'h13;
            5'h13: tbl6 = 6'h32;
            5'h14: tbl6 = 6'h0B;
            5'h15: tbl6 = 6'h2A;
            5'h16: tbl6 = 6'h1A;
            5'h17: tbl6 = 6'h3A;
            5'h18: tbl6 = 6'h33;
            5'h19: tbl6 = 6'h26;
            5'h1A: tbl6 = 6'h16;
            5'h1B: tbl6 = 6'h36;
            5'h1C: tbl6 = 6'h0E;
            5'h1D: tbl6 = 6'h2E;
            5'h1E: tbl6 = 6'h1E;
            default: tbl6 = 6'h2B;
        endcase
    endfunction

    function automatic logic [3:0] tbl4(input logic [2:0] y);
        case (y)
            3'h0: tbl4 = 4'hB;
            3'h1: tbl4 = 4'h9;
            3'h2: tbl4 = 4'h5;
            3'h3: tbl4 = 4'hC;
            3'h4: tbl4 = 4'hD;
            3'h5: tbl4 = 4'hA;
            3'h6: tbl4 = 4'h6;
            default: tbl4 = 4'hE;
        endcase
    endfunction

    // Tables hold the negative column, first-sent bit as MSB; the other column is derived
    function automatic tx_pcs_pkg::enc_out_t encode(input logic [7:0] b, input logic k, input logic rd);
        logic [5:0] s6;
        logic [3:0] s4;
        logic [2:0] n6;
        logic [2:0] n4;
        logic rd6;
        logic alt;
        logic [9:0] msb;
        tx_pcs_pkg::enc_out_t r;
        s6 = (k && b[4:0] == tx_pcs_pkg::K28_INDEX) ? tx_pcs_pkg::K28_SUBBLOCK6 : tbl6(b[4:0]);
        n6 = 3'($countones(s6));
        if (rd && (n6 != 3'h3 || b[4:0] == 5'h07)) begin
            s6 = ~s6;
        end
        rd6 = (n6 != 3'h3) ? ~rd : rd;
        alt = (b[7:5] == 3'h7) && (k || (!rd6 && (b[4:0] == 5'h11 || b[4:0] == 5'h12 || b[4:0] == 5'h14))
              || (rd6 && (b[4:0] == 5'h0B || b[4:0] == 5'h0D || b[4:0] == 5'h0E)));
        s4 = alt ? tx_pcs_pkg::ALT7_SUBBLOCK4 : tbl4(b[7:5]);
        n4 = 3'($countones(s4));
        if (rd6 && (n4 != 3'h2 || b[7:5] == 3'h3)) begin
            s4 = ~s4;
        end else if (!rd6 && k && n4 == 3'h2 && b[7:5] != 3'h3) begin
            s4 = ~s4;
        end
        r.rd = (n4 != 3'h2) ? ~rd6 : rd6;
        msb = {s6, s4};
        for (int i = 0; i < 10; i++) begin
            r.code[i] = msb[9 - i];
        end
        return r;
    endfunction

    tx_pcs_pkg::tx_phase_t phase_reg, phase_next;
    logic [1:0] sync_cnt_reg, sync_cnt_next;
    logic rd_reg, rd_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic half_sel_reg, half_sel_next;
    logic [9:0] hold_data_reg, hold_data_next;
    logic hold_ctrl_reg, hold_ctrl_next;
    logic [9:0] shift_reg, shift_next;
    logic serial_out_reg, word_take_reg, word_take_next;

    wire logic wide10 = cfg.enc_en | cfg.raw10_en;
    wire logic [3:0] last_bit = wide10 ? tx_pcs_pkg::LAST_BIT_10 : tx_pcs_pkg::LAST_BIT_8;
    wire logic boundary = bit_cnt_reg >= last_bit;
    wire logic ser_active = cfg.byte_ser_en & ~cfg.gigabit_ethernet_mode;
    wire logic raw10_path = ~cfg.enc_en & cfg.raw10_en;
    wire logic [9:0] lo_data = raw10_path ? parallel_in.data[9:0] : {2'h0, parallel_in.data[7:0]};
    wire logic [9:0] hi_data = raw10_path ? parallel_in.data[19:10] : {2'h0, parallel_in.data[15:8]};
    wire logic use_hold = ser_active & half_sel_reg;
    wire logic [9:0] cur_data = use_hold ? hold_data_reg : lo_data;
    wire logic cur_ctrl = use_hold ? hold_ctrl_reg : parallel_in.ctrl[0];
    wire logic in_data = phase_reg == tx_pcs_pkg::PH_DATA;
    // Override is a basic-mode feature; outside it the value input is ignored
    wire logic override_on = cfg.disparity_override_en & cfg.enc_en & ~cfg.gigabit_ethernet_mode;
    wire logic enc_rd_in = tx_logic_reset ? tx_pcs_pkg::RD_RESET :
                           (in_data && override_on) ? cfg.disparity_override_value : rd_reg;
    wire logic [7:0] enc_char = in_data ? cur_data[7:0] : tx_pcs_pkg::COMMA_CHAR;
    wire logic enc_k = ~in_data | cur_ctrl;
    wire tx_pcs_pkg::enc_out_t enc_out = encode(enc_char, enc_k, enc_rd_in);
    wire logic [9:0] raw_word = cfg.enc_en ? enc_out.code : (in_data ? cur_data : tx_pcs_pkg::WORD_RESET);

    logic [9:0] rev10;
    logic [9:0] rev8;
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_rev10
            assign rev10[gi] = raw_word[9 - gi];
        end
        for (gi = 0; gi < 10; gi++) begin : g_rev8
            if (gi < 8) begin : g_bit
                assign rev8[gi] = raw_word[7 - gi];
            end else begin : g_pad
                assign rev8[gi] = 1'b0;
            end
        end
    endgenerate

    wire logic rev_on = cfg.bit_reverse_en & ~cfg.gigabit_ethernet_mode;
    wire logic [9:0] ordered_word = rev_on ? (wide10 ? rev10 : rev8) : raw_word;
    wire logic [9:0] word_mask = wide10 ? tx_pcs_pkg::MASK_10 : tx_pcs_pkg::MASK_8;
    // Inversion sits last so it composes with reversal; toggling it upsets the far decoder briefly
    wire logic [9:0] line_word = ordered_word ^ (cfg.tx_bit_invert_en ? word_mask : tx_pcs_pkg::WORD_RESET);

    always_comb begin
        phase_next = phase_reg;
        sync_cnt_next = sync_cnt_reg;
        rd_next = rd_reg;
        half_sel_next = half_sel_reg;
        hold_data_next = hold_data_reg;
        hold_ctrl_next = hold_ctrl_reg;
        if (tx_logic_reset) begin
            phase_next = tx_pcs_pkg::PH_RESET;
            sync_cnt_next = tx_pcs_pkg::SYNC_CNT_RESET;
            rd_next = tx_pcs_pkg::RD_RESET;
            half_sel_next = 1'b0;
            hold_data_next = tx_pcs_pkg::WORD_RESET;
            hold_ctrl_next = 1'b0;
        end else if (boundary) begin
            if (cfg.enc_en) begin
                rd_next = enc_out.rd;
            end
            case (phase_reg)
                tx_pcs_pkg::PH_RESET: begin
                    // This boundary already emits the first synchronising comma
                    sync_cnt_next = 2'h1;
                    phase_next = cfg.enc_en ? tx_pcs_pkg::PH_SYNC : tx_pcs_pkg::PH_DATA;
                end
                tx_pcs_pkg::PH_SYNC: begin
                    sync_cnt_next = 2'(sync_cnt_reg + 2'h1);
                    if (2'(sync_cnt_reg + 2'h1) == tx_pcs_pkg::SYNC_GROUPS) begin
                        phase_next = tx_pcs_pkg::PH_DATA;
                    end
                end
                tx_pcs_pkg::PH_DATA: begin
                    half_sel_next = ser_active & ~half_sel_reg;
                    if (ser_active && !half_sel_reg) begin
                        hold_data_next = hi_data;
                        hold_ctrl_next = parallel_in.ctrl[1];
                    end
                end
                default: phase_next = tx_pcs_pkg::PH_RESET;
            endcase
        end
    end

    assign bit_cnt_next = boundary ? tx_pcs_pkg::BIT_CNT_RESET : 4'(bit_cnt_reg + 4'h1);
    assign shift_next = boundary ? line_word : {1'b0, shift_reg[9:1]};
    // Strobe is computed one cycle early and registered, so it is high in the boundary cycle straight from a flip-flop
    assign word_take_next = (bit_cnt_next == last_bit) && !tx_logic_reset
                            && (phase_next == tx_pcs_pkg::PH_DATA) && !(ser_active && half_sel_next);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= tx_pcs_pkg::PH_RESET;
            sync_cnt_reg <= tx_pcs_pkg::SYNC_CNT_RESET;
            rd_reg <= tx_pcs_pkg::RD_RESET;
            bit_cnt_reg <= tx_pcs_pkg::BIT_CNT_RESET;
            half_sel_reg <= 1'b0;
            hold_data_reg <= tx_pcs_pkg::WORD_RESET;
            hold_ctrl_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            sync_cnt_reg <= sync_cnt_next;
            rd_reg <= rd_next;
            bit_cnt_reg <= bit_cnt_next;
            half_sel_reg <= half_sel_next;
            hold_data_reg <= hold_data_next;
            hold_ctrl_reg <= hold_ctrl_next;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_reg <= tx_pcs_pkg::WORD_RESET;
            serial_out_reg <= 1'b0;
            word_take_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            serial_out_reg <= shift_next[0];
            word_take_reg <= word_take_next;
        end
    end

    assign word_take = word_take_reg;
    assign serial_out = serial_out_reg;
    assign running_disparity = rd_reg;
endmodule // tx_pcs_encode_serialize_path
`default_nettype wire

// ===== tx_pcs_pkg.sv
// Shared constants and carrier types for the transmit coding and serializing path
`default_nettype none
package tx_pcs_pkg;
    // Last bit index of a serializer word, 10-bit and 8-bit paths
    localparam logic [3:0] LAST_BIT_10 = 4'h9;
    localparam logic [3:0] LAST_BIT_8 = 4'h7;
    localparam logic [3:0] BIT_CNT_RESET = 4'h0;
    // Synchronising groups sent after the encoder leaves reset
    localparam logic [1:0] SYNC_GROUPS = 2'h3;
    localparam logic [1:0] SYNC_CNT_RESET = 2'h0;
    // Comma character and its first-transmitted-bit-at-bit-0 code group
    localparam logic [7:0] COMMA_CHAR = 8'hBC;
    localparam logic [9:0] COMMA_NEG_CODE = 10'h17C;
    localparam logic [5:0] K28_SUBBLOCK6 = 6'h0F;
    localparam logic [3:0] ALT7_SUBBLOCK4 = 4'h7;
    localparam logic [4:0] K28_INDEX = 5'h1C;
    localparam logic [9:0] WORD_RESET = 10'h000;
    localparam logic [9:0] MASK_10 = 10'h3FF;
    localparam logic [9:0] MASK_8 = 10'h0FF;
    // Running disparity: 0 is negative, 1 is positive
    localparam logic RD_RESET = 1'b0;

    typedef enum logic [1:0] {
        PH_RESET = 2'b00,
        PH_SYNC = 2'b01,
        PH_DATA = 2'b10
    } tx_phase_t;

    typedef struct packed {
        logic gigabit_ethernet_mode;    // Bypass the byte serializer, no reversal or override
        logic byte_ser_en;              // Split each wide word into two
        logic enc_en;                   // 8b/10b encoder in the path
        logic raw10_en;                 // 10-bit raw words when the encoder is off
        logic bit_reverse_en;           // Mirror the serializer word (basic mode)
        logic tx_bit_invert_en;         // Invert every bit of the serializer word
        logic disparity_override_en;    // Force the disparity of the current group
        logic disparity_override_value; // Forced disparity, 1 is positive
    } tx_cfg_t;

    typedef struct packed {
        logic [19:0] data;              // Wide word, low half sent first
        logic [1:0] ctrl;               // control_char_flag per character
    } tx_word_t;

    typedef struct packed {
        logic [9:0] code;
        logic rd;
    } enc_out_t;
endpackage
`default_nettype wire

// ===== tx_word_source.sv
// Core-side word source presenting queued words until the path takes them
`timescale 1ns/1ps
`default_nettype none
module tx_word_source (
    input wire logic ref_clk, // Clock
    input wire logic arst_n, // Reset, empties the queue
    input wire logic word_take, // Word consumed at this edge
    output var tx_pcs_pkg::tx_word_t parallel_in, // Presented word
    output var logic ovr_en, // Override enable with the word
    output var logic ovr_val // Override value with the word
);
    logic [23:0] q[$];
    logic took;
    initial begin
        parallel_in = '0;
        ovr_en = 1'h0;
        ovr_val = 1'h0;
    end
    always @(posedge ref_clk) begin
        took = word_take;
        #1;
        if (!arst_n) q.delete();
        else if (took && q.size() > 0) void'(q.pop_front());
        // Empty queue shows a changing pattern so stale data never passes for a word
        if (q.size() > 0) {ovr_en, ovr_val, parallel_in} = q[0];
        else {ovr_en, ovr_val, parallel_in} = {2'h0, ~parallel_in};
    end
endmodule // tx_word_source
`default_nettype wire
